// File: verilog/ocd_top.sv
// Oscillator switch handshake and doze clock divisor control.
// Assumes software on a plain 16-bit register port; one clock.
//
// Overview of operation
// - Writing request bit one while idle starts a switch, except a direct PLL-to-PLL move.
// - Request bit clears when switch completes.
// - Oscillator control writes need unlock sequence first.
// - Recover bit: interrupt clears doze enable.
// - Reduction code 111/110/101/011 divides 128/64/32/8.
// - Doze off holds ratio at one.
// - Reduction field writes ignored while doze on.
// - Doze enable cannot set while code zero.
`timescale 1ns/1ns
module ocd_top #(
	parameter int SWITCH_CYC = ocd_pkg::SWITCH_CYCLES // Source settling cycles
) (
	input  wire logic        i_clk,      // System clock, 250 MHz
	input  wire logic        i_rst_n,    // Sync reset, active low
	input  wire logic [1:0]  i_addr,     // Register index
	input  wire logic [15:0] i_wdata,    // Write data
	input  wire logic        i_wr,       // Write strobe
	input  wire logic        i_rd,       // Read strobe
	input  wire logic        i_irq,      // Any interrupt, level
	output logic      [15:0] o_rdata,    // Read data, cycle after strobe
	output logic      [2:0]  o_osc_sel,  // Active oscillator source
	output logic             o_cpu_en,   // Processor clock enable
	output logic             o_doze_act  // Doze ratio in force
);
	typedef enum logic [1:0] {OCD_IDLE, OCD_SETTLE, OCD_DONE} ocd_state_e;

	ocd_state_e  state;
	logic [2:0]  new_osc;
	logic        osc_req;
	logic        recover_on_irq;
	logic [2:0]  doze_code;
	logic        doze_ratio_enable;
	logic        key1_seen;
	logic        armed;
	logic        refused;
	logic [15:0] settle_cnt;

	logic        wr_osc;
	logic        wr_div;
	logic        wr_unl;
	logic        wr_sts;
	logic        osc_ok;
	logic        pll_cross;
	logic        switch_done;
	logic [2:0]  next_doze_code;
	logic        next_doze_en;

	ocd_if dz ();

	// Write decode; the control write counts only when armed
	assign wr_unl = i_wr && (i_addr == ocd_pkg::ADDR_UNLOCK);
	assign wr_div = i_wr && (i_addr == ocd_pkg::ADDR_CLK_DIV);
	assign wr_sts = i_wr && (i_addr == ocd_pkg::ADDR_STATUS);
	assign wr_osc = i_wr && (i_addr == ocd_pkg::ADDR_OSC_CTRL);
	assign osc_ok = wr_osc && armed;

	// Direct moves between the two PLL sources are refused, not carried out
	always_comb begin
		pll_cross = 1'b0;
		if ((o_osc_sel == ocd_pkg::OSC_PRIMARY_PLL) &&
		    (i_wdata[ocd_pkg::NEW_OSC_LSB +: 3] == ocd_pkg::OSC_FAST_RC_WITH_PLL)) begin
			pll_cross = 1'b1;
		end
		if ((o_osc_sel == ocd_pkg::OSC_FAST_RC_WITH_PLL) &&
		    (i_wdata[ocd_pkg::NEW_OSC_LSB +: 3] == ocd_pkg::OSC_PRIMARY_PLL)) begin
			pll_cross = 1'b1;
		end
	end

	// Unlock sequence: key1 then key2 on consecutive register writes
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			key1_seen <= 1'b0;
			armed     <= 1'b0;
		end else if (i_wr) begin
			key1_seen <= wr_unl && (i_wdata == ocd_pkg::UNLOCK_KEY1);
			armed     <= wr_unl && key1_seen && (i_wdata == ocd_pkg::UNLOCK_KEY2);
		end
	end

	// New source selection, only latched by an armed write
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			new_osc <= ocd_pkg::OSC_RESET;
		end else if (osc_ok && (state == OCD_IDLE)) begin
			new_osc <= i_wdata[ocd_pkg::NEW_OSC_LSB +: 3];
		end
	end

	// Switch sequencer; the selection is frozen while a switch is busy
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state <= OCD_IDLE;
		end else begin
			case (state)
				OCD_IDLE: begin
					if (osc_ok && i_wdata[ocd_pkg::OSC_REQ_BIT] && !pll_cross) begin
						state <= OCD_SETTLE;
					end
				end
				OCD_SETTLE: begin
					if (switch_done) begin
						state <= OCD_DONE;
					end
				end
				OCD_DONE: state <= OCD_IDLE;
				default:  state <= OCD_IDLE;
			endcase
		end
	end

	// Settling counter for the source change
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			settle_cnt <= '0;
		end else if (state == OCD_SETTLE) begin
			settle_cnt <= settle_cnt + 16'h0001;
		end else begin
			settle_cnt <= '0;
		end
	end
	assign switch_done = (settle_cnt == 16'(SWITCH_CYC - 1));

	// Request bit: set by software, returned to zero by the device at the end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			osc_req <= 1'b0;
		end else if (state == OCD_IDLE && osc_ok && i_wdata[ocd_pkg::OSC_REQ_BIT]
		             && !pll_cross) begin
			osc_req <= 1'b1;
		end else if (state == OCD_DONE) begin
			osc_req <= 1'b0;
		end
	end

	// Active source changes only when the switch completes
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_osc_sel <= ocd_pkg::OSC_RESET;
		end else if (state == OCD_SETTLE && switch_done) begin
			o_osc_sel <= new_osc;
		end
	end

	// Sticky refusal flag; write one clears, a new refusal wins over the clear
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			refused <= 1'b0;
		end else if (osc_ok && i_wdata[ocd_pkg::OSC_REQ_BIT] && pll_cross) begin
			refused <= 1'b1;
		end else if (wr_sts && i_wdata[ocd_pkg::ST_REFUSED_BIT]) begin
			refused <= 1'b0;
		end
	end

	// Next clock divisor values after write filtering
	always_comb begin
		next_doze_code = doze_code;
		next_doze_en   = doze_ratio_enable;
		if (wr_div) begin
			if (!doze_ratio_enable) begin
				next_doze_code = i_wdata[ocd_pkg::DOZE_LSB +: 3];
			end
			if (next_doze_code == 3'h0) begin
				next_doze_en = 1'b0;
			end else begin
				next_doze_en = i_wdata[ocd_pkg::DOZE_EN_BIT];
			end
		end
		if (recover_on_irq && i_irq) begin
			next_doze_en = 1'b0;
		end
	end

	// Clock divisor control register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			recover_on_irq    <= 1'b0;
			doze_code         <= ocd_pkg::DOZE_RESET;
			doze_ratio_enable <= 1'b0;
		end else begin
			if (wr_div) begin
				recover_on_irq <= i_wdata[ocd_pkg::RECOVER_BIT];
			end
			doze_code         <= next_doze_code;
			doze_ratio_enable <= next_doze_en;
		end
	end

	// Divider sees the registered controls; ratio is one while disabled
	assign dz.doze_en   = doze_ratio_enable;
	assign dz.doze_code = doze_code;

	ocd_doze_div u_div (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.dz      (dz)
	);

	// Outputs straight from flops
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_cpu_en   <= 1'b0;
			o_doze_act <= 1'b0;
		end else begin
			o_cpu_en   <= dz.cpu_tick;
			o_doze_act <= doze_ratio_enable;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			case (i_addr)
				ocd_pkg::ADDR_OSC_CTRL: begin
					o_rdata <= {1'b0, o_osc_sel, 1'b0, new_osc, 7'h00, osc_req};
				end
				ocd_pkg::ADDR_CLK_DIV: begin
					o_rdata <= {recover_on_irq, doze_code, doze_ratio_enable, 11'h000};
				end
				ocd_pkg::ADDR_STATUS: begin
					o_rdata <= {13'h0000, refused, (state != OCD_IDLE), armed};
				end
				default: o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end
endmodule : ocd_top

// File: common/ocd_pkg.sv
// Constants for the oscillator switch and doze divider block.
// Assumes a single 250 MHz clock and a 16-bit register port.
package ocd_pkg;
	// Register indexes on the plain register port
	localparam logic [1:0] ADDR_OSC_CTRL = 2'h0;
	localparam logic [1:0] ADDR_CLK_DIV  = 2'h1;
	localparam logic [1:0] ADDR_UNLOCK   = 2'h2;
	localparam logic [1:0] ADDR_STATUS   = 2'h3;

	// Oscillator control fields
	localparam int OSC_REQ_BIT  = 0;
	localparam int NEW_OSC_LSB  = 8;
	localparam int CUR_OSC_LSB  = 12;

	// Clock divisor control fields
	localparam int RECOVER_BIT  = 15;
	localparam int DOZE_LSB     = 12;
	localparam int DOZE_EN_BIT  = 11;

	// Status fields
	localparam int ST_ARMED_BIT = 0;
	localparam int ST_BUSY_BIT  = 1;
	localparam int ST_REFUSED_BIT = 2;

	// Reset values
	localparam logic [2:0] DOZE_RESET    = 3'h3;
	localparam logic [2:0] OSC_RESET     = 3'h0;

	// Unlock keys, written back to back
	localparam logic [15:0] UNLOCK_KEY1  = 16'h0057;
	localparam logic [15:0] UNLOCK_KEY2  = 16'h00aa;

	// Oscillator source codes
	localparam logic [2:0] OSC_FAST_RC          = 3'h0;
	localparam logic [2:0] OSC_FAST_RC_WITH_PLL = 3'h1;
	localparam logic [2:0] OSC_PRIMARY          = 3'h2;
	localparam logic [2:0] OSC_PRIMARY_PLL      = 3'h3;

	// Settling time of a source change
	localparam int CLK_PERIOD_NS   = 4;
	localparam int SWITCH_TIME_NS  = 64;
	localparam int SWITCH_CYCLES   = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Width of the doze prescale counter (largest ratio 128)
	localparam int DOZE_CNT_W      = 7;
endpackage : ocd_pkg

// File: common/ocd_if.sv
// Carrier between the control registers and the doze divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ocd_if;
	logic       doze_en;   // Reduction active
	logic [2:0] doze_code; // Reduction code
	logic       cpu_tick;  // Processor clock enable
	modport ctrl (output doze_en, output doze_code, input cpu_tick);
	modport div  (input doze_en, input doze_code, output cpu_tick);
endinterface : ocd_if

// File: verilog/ocd_doze_div.sv
// Doze divider: makes the processor clock enable pulse.
// Assumes code and enable come from the control registers.
`timescale 1ns/1ns
module ocd_doze_div (
	input  wire logic i_clk,   // System clock
	input  wire logic i_rst_n, // Sync reset, active low
	ocd_if.div        dz       // Control and tick
);
	logic [ocd_pkg::DOZE_CNT_W-1:0] cnt;
	logic [ocd_pkg::DOZE_CNT_W-1:0] last;

	// Code 111 is 128, 100 is 16, 011 is 8: ratio is two to the code
	always_comb begin
		last = '0;
		if (dz.doze_en) begin
			last = ocd_pkg::DOZE_CNT_W'((8'h01 << dz.doze_code) - 8'h01);
		end
	end

	// Counter restarts on every tick; it is compared with the live limit, so a code change takes effect at once
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt         <= '0;
			dz.cpu_tick <= 1'b0;
		end else if (cnt >= last) begin
			cnt         <= '0;
			dz.cpu_tick <= 1'b1; // Every cycle when doze is off
		end else begin
			cnt         <= cnt + 1'b1;
			dz.cpu_tick <= 1'b0;
		end
	end
endmodule : ocd_doze_div

// File: tb/ocd_top_props.sv
// Port-level properties of ocd_top.
// Assumes it is bound into ocd_top with the same SWITCH_CYC.
`timescale 1ns/1ns
module ocd_top_props #(
	parameter int SWITCH_CYC = 16 // Settling cycles
) (
	input wire logic        i_clk,     // Clock
	input wire logic        i_rst_n,   // Reset
	input wire logic [1:0]  i_addr,    // Index
	input wire logic [15:0] i_wdata,   // Write data
	input wire logic        i_wr,      // Write
	input wire logic        i_rd,      // Read
	input wire logic        i_irq,     // Interrupt
	input wire logic [15:0] o_rdata,   // Read data
	input wire logic [2:0]  o_osc_sel, // Source
	input wire logic        o_cpu_en,  // Tick
	input wire logic        o_doze_act // Doze on
);
	logic [7:0] since_wr; // Cycles since osc write
	logic       rec_shd;  // Recover bit shadow
	logic [8:0] gap;      // Cycles since tick
	logic [8:0] last_gap; // Previous spacing
	logic [1:0] n_tick;   // Ticks inside doze
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Saturates, so reset never looks like a fresh write
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			since_wr <= 8'hff;
		else if (i_wr && i_addr == ocd_pkg::ADDR_OSC_CTRL)
			since_wr <= 8'h00;
		else if (since_wr != 8'hff)
			since_wr <= since_wr + 8'h01;
	end
	// Shadow of the recover bit
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			rec_shd <= 1'b0;
		else if (i_wr && i_addr == ocd_pkg::ADDR_CLK_DIV)
			rec_shd <= i_wdata[ocd_pkg::RECOVER_BIT];
	end
	// First doze gap is partial, so only later ones count
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !o_doze_act)
			n_tick <= 2'h0;
		else if (o_cpu_en && n_tick != 2'h3)
			n_tick <= n_tick + 2'h1;
	end
	always_ff @(posedge i_clk) begin
		gap <= o_cpu_en ? 9'h001 : gap + 9'h001;
		last_gap <= o_cpu_en ? gap : last_gap;
	end
	sequence s_div_wr0;
		i_wr && i_addr == ocd_pkg::ADDR_CLK_DIV && i_wdata[14:12] == 3'h0;
	endsequence
	sequence s_doze_held;
		o_doze_act [*2];
	endsequence
	property p_rd_idle;
		!$past(i_rd) |-> o_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("data outside read");
	property p_req_done;
		i_rd && i_addr == ocd_pkg::ADDR_OSC_CTRL && since_wr > SWITCH_CYC + 4 |=> !o_rdata[0];
	endproperty
	a_req_done: assert property (p_req_done) else $error("request stuck");
	property p_sel_settle;
		$changed(o_osc_sel) |-> since_wr >= SWITCH_CYC - 1 && since_wr <= SWITCH_CYC + 3;
	endproperty
	a_sel_settle: assert property (p_sel_settle) else $error("source moved");
	property p_recover;
		rec_shd && i_irq |-> ##2 !o_doze_act;
	endproperty
	a_recover: assert property (p_recover) else $error("doze kept");
	property p_tick;
		o_cpu_en && o_doze_act ##1 s_doze_held |-> !$past(o_cpu_en);
	endproperty
	a_tick: assert property (p_tick) else $error("tick too dense");
	property p_full_rate;
		!o_doze_act [*6] |-> $past(o_cpu_en);
	endproperty
	a_full_rate: assert property (p_full_rate) else $error("tick missing");
	property p_ratio_held;
		o_cpu_en && n_tick == 2'h3 && gap != last_gap |=> !o_doze_act;
	endproperty
	a_ratio_held: assert property (p_ratio_held) else $error("ratio moved");
	property p_no_code0;
		!o_doze_act && !$past(i_wr) ##0 s_div_wr0 |-> ##2 !o_doze_act;
	endproperty
	a_no_code0: assert property (p_no_code0) else $error("doze at code 0");
endmodule : ocd_top_props

// File: tb/ocd_top_bench.sv
// Self-checking bench driving ocd_top over its register port.
// Assumes ocd_pkg, ocd_top and ocd_top_props compiled first.
`timescale 1ns/1ns
module osc_switch_and_doze_divider_bench;
	localparam logic [1:0] A_OSC = ocd_pkg::ADDR_OSC_CTRL;
	localparam logic [1:0] A_DIV = ocd_pkg::ADDR_CLK_DIV;
	localparam logic [1:0] A_UNL = ocd_pkg::ADDR_UNLOCK;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [1:0]  i_addr = 2'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        i_irq = 1'b0;
	logic [15:0] o_rdata;
	logic [2:0]  o_osc_sel;
	logic        o_cpu_en;
	logic        o_doze_act;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cyc = 0;
	ocd_top #(.SWITCH_CYC(4)) i_dut (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
		.i_irq, .o_rdata, .o_osc_sel, .o_cpu_en, .o_doze_act);
	// Clock and hang limit
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic tick();
		@(posedge i_clk);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Bus cycles, one strobe cycle each
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [15:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rd
	task automatic osc_sw(input logic [2:0] src, input logic [2:0] exp);
		wr(A_UNL, ocd_pkg::UNLOCK_KEY1);
		wr(A_UNL, ocd_pkg::UNLOCK_KEY2);
		wr(A_OSC, {5'h00, src, 8'h01});
		repeat (12) tick();
		chk({13'h0000, o_osc_sel}, {13'h0000, exp});
	endtask : osc_sw
	// Spacing between two processor ticks
	task automatic gap_chk(input int n);
		int k;
		k = 0;
		repeat (4) tick();
		while (o_cpu_en !== 1'b1 && k < 300) begin
			tick();
			k++;
		end
		k = 1;
		tick();
		while (o_cpu_en !== 1'b1 && k < 300) begin
			tick();
			k++;
		end
		chk(k[15:0], n[15:0]);
	endtask : gap_chk
	task automatic t_switch();
		wr(A_UNL, ocd_pkg::UNLOCK_KEY1);
		wr(A_UNL, ocd_pkg::UNLOCK_KEY2);
		rd(ocd_pkg::ADDR_STATUS, 16'h0001);
		wr(A_OSC, 16'h0201);
		rd(A_OSC, 16'h0201);
		rd(ocd_pkg::ADDR_STATUS, 16'h0002);
		repeat (10) tick();
		rd(A_OSC, 16'h2200);
		wr(A_OSC, 16'h0001);
		repeat (10) tick();
		rd(A_OSC, 16'h2200);
		osc_sw(ocd_pkg::OSC_PRIMARY_PLL, 3'h3);
		osc_sw(ocd_pkg::OSC_FAST_RC_WITH_PLL, 3'h3);
		rd(ocd_pkg::ADDR_STATUS, 16'h0004);
		wr(ocd_pkg::ADDR_STATUS, 16'h0004);
		rd(ocd_pkg::ADDR_STATUS, 16'h0000);
		osc_sw(ocd_pkg::OSC_FAST_RC, 3'h0);
		osc_sw(ocd_pkg::OSC_FAST_RC_WITH_PLL, 3'h1);
	endtask : t_switch
	task automatic t_doze();
		int c;
		for (c = 1; c < 8; c++) begin
			wr(A_DIV, 16'h0000);
			wr(A_DIV, {1'b0, c[2:0], 12'h800});
			gap_chk(1 << c);
		end
		wr(A_DIV, 16'h1800);
		rd(A_DIV, 16'h7800);
		chk({15'h0000, o_doze_act}, 16'h0001);
		gap_chk(128);
		wr(A_DIV, 16'h7000);
		repeat (3) tick();
		chk({15'h0000, o_cpu_en}, 16'h0001);
		chk({15'h0000, o_doze_act}, 16'h0000);
		wr(A_DIV, 16'h0000);
		wr(A_DIV, 16'h0800);
		rd(A_DIV, 16'h0000);
	endtask : t_doze
	task automatic t_recover();
		wr(A_DIV, 16'hb800);
		@(posedge i_clk);
		i_irq <= 1'b1;
		repeat (3) tick();
		rd(A_DIV, 16'hb000);
		chk({15'h0000, o_doze_act}, 16'h0000);
		wr(A_DIV, 16'hb800);
		rd(A_DIV, 16'hb000);
		@(posedge i_clk);
		i_irq <= 1'b0;
		wr(A_DIV, 16'h3800);
		@(posedge i_clk);
		i_irq <= 1'b1;
		repeat (3) tick();
		@(posedge i_clk);
		i_irq <= 1'b0;
		rd(A_DIV, 16'h3800);
	endtask : t_recover
	task automatic final_report();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// Main sequence after two reset cycles
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(A_DIV, 16'h3000);
		rd(A_UNL, 16'h0000);
		t_switch();
		t_doze();
		t_recover();
		final_report();
	end
endmodule : osc_switch_and_doze_divider_bench
bind ocd_top ocd_top_props #(.SWITCH_CYC(SWITCH_CYC)) i_props (.i_clk, .i_rst_n, .i_addr,
	.i_wdata, .i_wr, .i_rd, .i_irq, .o_rdata, .o_osc_sel, .o_cpu_en, .o_doze_act);
